// file: rxdq_dma.v
/*
 * Receive channel of a descriptor-based DMA: moves endpoint FIFO bytes into linked buffers in memory.
 * Assumes an APB master, a word memory port with a one-cycle ack per held request, and a byte FIFO.
 */
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "rxdq_regs.vh"

// Operation
// RULE1: Set first flag on packet's first buffer.
// RULE2: Software clears first flag before queuing.
// RULE3: Set last flag on packet's final buffer.
// RULE4: Software clears last flag before queuing.
// RULE5: Software sets ownership on first descriptor.
// RULE6: Clear ownership when packet fully handled.
// RULE7: Set queue end on last queue buffer.
// RULE8: Queue end only together with last flag.
// RULE9: Software clears queue end before queuing.
// RULE10: Set zero flag for empty packet.
// RULE11: Software ignores length when zero flag set.
// RULE12: Packet length only in first descriptor.
// RULE13: Data beyond packet length is not stored.
// RULE14: First, middle and last descriptor marking.
// RULE15: Separate receive state for every channel.
// RULE16: One queue per channel, head and completion.
// RULE17: Per-channel head, completion, pointers, lengths.
// RULE18: Software appends at tail, DMA frees head.
// RULE19: Follow next links through successive buffers.
// RULE20: Zero next pointer ends queue advance.
// RULE21: Descriptors are 16-byte aligned, four words.
// RULE22: Reserved status bits written as zero.
// RULE23: First descriptor status written after data.
module rxdq_dma #(
  parameter NCH = 2,
  parameter CHW = 1
) (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  mem_req,
  mem_we,
  mem_addr,
  mem_be,
  mem_wdata,
  mem_rdata,
  mem_ack,
  fifo_valid,
  fifo_chan,
  fifo_data,
  fifo_last,
  fifo_zero,
  fifo_ready,
  busy
);
  input wire pclk;
  input wire presetn;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  output reg mem_req;
  output reg mem_we;
  output reg [31:0] mem_addr;
  output reg [3:0] mem_be;
  output reg [31:0] mem_wdata;
  input wire [31:0] mem_rdata;
  input wire mem_ack;
  input wire fifo_valid;
  input wire [CHW-1:0] fifo_chan;
  input wire [7:0] fifo_data;
  input wire fifo_last;
  input wire fifo_zero;
  output reg fifo_ready;
  output reg busy;

  // ----------------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------------
  localparam S_IDLE = 4'h0;
  localparam S_RDNXT = 4'h1;
  localparam S_RDBUF = 4'h2;
  localparam S_RDLEN = 4'h3;
  localparam S_DATA = 4'h4;
  localparam S_WRB = 4'h5;
  localparam S_WRMID = 4'h6;
  localparam S_WRLEN = 4'h7;
  localparam S_WRLAST = 4'h8;
  localparam S_WRFIRST = 4'h9;
  localparam S_DRAIN = 4'hA;

  // ----------------------------------------------------------------------------
  // Per-channel receive state and the global control register
  // ----------------------------------------------------------------------------
  reg [31:0] head_r [0:NCH-1]; // RULE15 RULE16 RULE17
  reg [31:0] comp_r [0:NCH-1];
  reg [31:0] first_r [0:NCH-1];
  reg [31:0] cur_r [0:NCH-1];
  reg [31:0] bufp_r [0:NCH-1];
  reg [31:0] len_r [0:NCH-1];
  reg [31:0] ctrl_r;

  reg [3:0] state_r;
  reg [CHW-1:0] ch_r;
  reg [31:0] next_r;
  reg [15:0] buflen_r;
  reg is_first_r;
  reg single_r;
  reg zero_r;
  reg [7:0] byte_r;
  reg byte_last_r;
  integer i;

  wire [31:0] st_word;
  wire fmt_first;
  wire fmt_last;
  wire [31:0] ch_len;
  wire [15:0] ch_rem;
  wire [15:0] ch_act;
  wire ch_sel_ok;

  assign ch_len = len_r[ch_r];
  assign ch_rem = ch_len[31:16];
  assign ch_act = ch_len[15:0];
  assign fmt_first = (state_r == S_WRFIRST);
  assign fmt_last = (state_r == S_WRFIRST) ? single_r : (state_r == S_WRLAST);
  assign ch_sel_ok = ({{(32-CHW){1'b0}}, fifo_chan} < NCH);

  rxdq_status_fmt u_fmt (
    .first_buffer_flag(fmt_first),
    .last_buffer_flag(fmt_last),
    .queue_end_flag(next_r == 32'h0000_0000), // RULE7
    .zero_byte(zero_r),
    .pkt_len(ch_act),
    .status_word(st_word)
  );

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  function [2:0] reg_sel;
    input [5:0] off;
    begin
      case (off)
        `RXDQ_OFF_STATE_WORD0: reg_sel = 3'h0;
        `RXDQ_OFF_COMPLETION: reg_sel = 3'h1;
        `RXDQ_OFF_FIRST_DESC: reg_sel = 3'h2;
        `RXDQ_OFF_CUR_DESC: reg_sel = 3'h3;
        `RXDQ_OFF_CUR_BUF: reg_sel = 3'h4;
        `RXDQ_OFF_LEN_TRACK: reg_sel = 3'h5;
        `RXDQ_OFF_ENGINE: reg_sel = 3'h6;
        default: reg_sel = 3'h7;
      endcase
    end
  endfunction

  wire [CHW-1:0] a_ch;
  wire [2:0] a_sel;
  wire a_ctrl;
  wire a_chan_ok;
  wire a_ok;
  wire apb_setup;
  wire apb_wr;
  reg [31:0] rd_mux;

  assign a_ch = paddr[`RXDQ_CH_STRIDE_LOG2+CHW-1:`RXDQ_CH_STRIDE_LOG2];
  assign a_sel = reg_sel(paddr[5:0]);
  assign a_ctrl = (paddr == `RXDQ_OFF_CTRL);
  assign a_chan_ok = (paddr[11:`RXDQ_CH_STRIDE_LOG2+CHW] == {(12-`RXDQ_CH_STRIDE_LOG2-CHW){1'b0}}) &&
                     ({{(32-CHW){1'b0}}, a_ch} < NCH) && (a_sel != 3'h7);
  assign a_ok = a_ctrl || a_chan_ok;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite && a_ok && !pslverr;

  always @* begin
    rd_mux = 32'h0000_0000;
    if (a_ctrl) begin
      rd_mux = ctrl_r;
    end else if (a_chan_ok) begin
      case (a_sel)
        3'h0: rd_mux = head_r[a_ch];
        3'h1: rd_mux = comp_r[a_ch];
        3'h2: rd_mux = first_r[a_ch];
        3'h3: rd_mux = cur_r[a_ch];
        3'h4: rd_mux = bufp_r[a_ch];
        3'h5: rd_mux = len_r[a_ch];
        3'h6: rd_mux = {24'h00_0000, (state_r != S_IDLE) && (ch_r == a_ch), 3'h0, state_r};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Answers are registered at the setup edge, so every access completes with no wait state.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup && !a_ok;
      if (apb_setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Engine and state write-back
  // ----------------------------------------------------------------------------
  // Engine updates win over a same-cycle software write to the active channel, so that a
  // head or completion pointer moved by the hardware is never lost.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < NCH; i = i + 1) begin
        head_r[i] <= 32'h0000_0000;
        comp_r[i] <= 32'h0000_0000;
        first_r[i] <= 32'h0000_0000;
        cur_r[i] <= 32'h0000_0000;
        bufp_r[i] <= 32'h0000_0000;
        len_r[i] <= 32'h0000_0000;
      end
      ctrl_r <= `RXDQ_CTRL_RESET;
      state_r <= S_IDLE;
      ch_r <= {CHW{1'b0}};
      next_r <= 32'h0000_0000;
      buflen_r <= 16'h0000;
      is_first_r <= 1'b0;
      single_r <= 1'b0;
      zero_r <= 1'b0;
      byte_r <= 8'h00;
      byte_last_r <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_be <= 4'h0;
      mem_wdata <= 32'h0000_0000;
      fifo_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (apb_wr) begin
        if (a_ctrl) begin
          ctrl_r <= {31'h0000_0000, pwdata[`RXDQ_CTRL_EN_BIT]};
        end else begin
          case (a_sel)
            3'h0: head_r[a_ch] <= pwdata; // RULE18
            3'h1: comp_r[a_ch] <= pwdata;
            3'h2: first_r[a_ch] <= pwdata;
            3'h3: cur_r[a_ch] <= pwdata;
            3'h4: bufp_r[a_ch] <= pwdata;
            3'h5: len_r[a_ch] <= pwdata;
            default: ;
          endcase
        end
      end
      busy <= (state_r != S_IDLE);
      case (state_r)
        S_IDLE: begin
          if (fifo_valid && ch_sel_ok && ctrl_r[`RXDQ_CTRL_EN_BIT] && (head_r[fifo_chan] != 32'h0000_0000)) begin
            ch_r <= fifo_chan;
            first_r[fifo_chan] <= head_r[fifo_chan];
            cur_r[fifo_chan] <= head_r[fifo_chan];
            len_r[fifo_chan] <= 32'h0000_0000;
            is_first_r <= 1'b1;
            single_r <= 1'b1;
            zero_r <= 1'b0;
            state_r <= S_RDNXT;
          end
        end
        S_RDNXT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            next_r <= mem_rdata; // RULE19
            state_r <= S_RDBUF;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_be <= 4'hF;
            mem_addr <= cur_r[ch_r] + `RXDQ_DESC_NEXT;
          end
        end
        S_RDBUF: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            bufp_r[ch_r] <= mem_rdata;
            state_r <= S_RDLEN;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_addr <= cur_r[ch_r] + `RXDQ_DESC_BUF;
          end
        end
        S_RDLEN: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            buflen_r <= mem_rdata[15:0];
            len_r[ch_r] <= {mem_rdata[15:0], ch_act};
            state_r <= S_DATA;
            fifo_ready <= 1'b1;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_addr <= cur_r[ch_r] + `RXDQ_DESC_LEN;
          end
        end
        S_DATA: begin
          if (fifo_valid && fifo_ready) begin
            fifo_ready <= 1'b0;
            if (fifo_zero) begin
              zero_r <= (ch_act == 16'h0000); // RULE10
              state_r <= S_WRLEN;
            end else if (ch_rem == 16'h0000) begin
              state_r <= S_DRAIN; // RULE13
              fifo_ready <= !fifo_last;
              if (fifo_last) begin
                state_r <= S_WRLEN;
              end
            end else begin
              byte_r <= fifo_data;
              byte_last_r <= fifo_last;
              state_r <= S_WRB;
            end
          end
        end
        S_WRB: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            bufp_r[ch_r] <= bufp_r[ch_r] + 32'h0000_0001;
            len_r[ch_r] <= {ch_rem - 16'h0001, ch_act + 16'h0001};
            if (byte_last_r) begin
              state_r <= S_WRLEN;
            end else if (ch_rem != 16'h0001) begin
              state_r <= S_DATA;
              fifo_ready <= 1'b1;
            end else if (next_r == 32'h0000_0000) begin
              state_r <= S_DRAIN; // RULE20
              fifo_ready <= 1'b1;
            end else begin
              state_r <= S_WRMID;
            end
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= {bufp_r[ch_r][31:2], 2'b00};
            mem_be <= 4'h1 << bufp_r[ch_r][1:0];
            mem_wdata <= {4{byte_r}};
          end
        end
        S_DRAIN: begin
          // Bytes with no buffer left are dropped; the packet is closed with what was stored.
          if (fifo_valid && fifo_ready && fifo_last) begin
            fifo_ready <= 1'b0;
            state_r <= S_WRLEN;
          end
        end
        S_WRMID: begin
          if (is_first_r || mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            is_first_r <= 1'b0;
            single_r <= 1'b0;
            cur_r[ch_r] <= next_r; // RULE19
            state_r <= S_RDNXT;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_be <= 4'hF;
            mem_addr <= cur_r[ch_r] + `RXDQ_DESC_STATUS;
            mem_wdata <= st_word; // RULE14
          end
        end
        S_WRLEN: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state_r <= is_first_r ? S_WRFIRST : S_WRLAST;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_be <= 4'hF;
            mem_addr <= cur_r[ch_r] + `RXDQ_DESC_LEN;
            mem_wdata <= {16'h0000, buflen_r - ch_rem};
          end
        end
        S_WRLAST: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state_r <= S_WRFIRST;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= cur_r[ch_r] + `RXDQ_DESC_STATUS;
            mem_wdata <= st_word; // RULE3 RULE7 RULE8
          end
        end
        S_WRFIRST: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            comp_r[ch_r] <= cur_r[ch_r];
            head_r[ch_r] <= next_r; // RULE18 RULE20
            state_r <= S_IDLE;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= first_r[ch_r] + `RXDQ_DESC_STATUS;
            mem_wdata <= st_word; // RULE1 RULE6 RULE12 RULE23
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // rxdq_dma

// file: rxdq_regs.vh
/*
 * Register offsets, descriptor field positions and reset values of the receive descriptor queue DMA.
 * Assumes a 32-bit APB register window and 16-byte aligned descriptors of four words in memory.
 */
`ifndef RXDQ_REGS_VH
`define RXDQ_REGS_VH

// ----------------------------------------------------------------------------
// Per-channel register block, byte offsets inside a channel stride
// ----------------------------------------------------------------------------
`define RXDQ_CH_STRIDE_LOG2 6
`define RXDQ_OFF_STATE_WORD0 6'h00
`define RXDQ_OFF_COMPLETION 6'h04
`define RXDQ_OFF_FIRST_DESC 6'h08
`define RXDQ_OFF_CUR_DESC 6'h0C
`define RXDQ_OFF_CUR_BUF 6'h10
`define RXDQ_OFF_LEN_TRACK 6'h14
`define RXDQ_OFF_ENGINE 6'h18

// ----------------------------------------------------------------------------
// Global control register
// ----------------------------------------------------------------------------
`define RXDQ_OFF_CTRL 12'h100
`define RXDQ_CTRL_EN_BIT 0
`define RXDQ_CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// Descriptor word offsets
// ----------------------------------------------------------------------------
`define RXDQ_DESC_NEXT 32'h0000_0000
`define RXDQ_DESC_BUF 32'h0000_0004
`define RXDQ_DESC_LEN 32'h0000_0008
`define RXDQ_DESC_STATUS 32'h0000_000C

// ----------------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------------
`define RXDQ_ST_FIRST_BIT 31
`define RXDQ_ST_LAST_BIT 30
`define RXDQ_ST_OWNER_BIT 29
`define RXDQ_ST_QEND_BIT 28
`define RXDQ_ST_ZERO_BIT 23
`define RXDQ_ST_LEN_MSB 15

`endif

// file: rxdq_status_fmt.v
/*
 * Builds the status word written back into a receive descriptor.
 * Passes the queue end input on only together with the last buffer input; the caller may raise it alone.
 */
`timescale 1ns/1ps
`include "rxdq_regs.vh"

module rxdq_status_fmt (
  first_buffer_flag,
  last_buffer_flag,
  queue_end_flag,
  zero_byte,
  pkt_len,
  status_word
);
  input wire first_buffer_flag;
  input wire last_buffer_flag;
  input wire queue_end_flag;
  input wire zero_byte;
  input wire [15:0] pkt_len;
  output reg [31:0] status_word;

  always @* begin
    status_word = 32'h0000_0000; // RULE22
    status_word[`RXDQ_ST_FIRST_BIT] = first_buffer_flag; // RULE1
    status_word[`RXDQ_ST_LAST_BIT] = last_buffer_flag; // RULE3
    status_word[`RXDQ_ST_OWNER_BIT] = 1'b0; // RULE6
    status_word[`RXDQ_ST_QEND_BIT] = queue_end_flag & last_buffer_flag; // RULE8
    status_word[`RXDQ_ST_ZERO_BIT] = zero_byte & first_buffer_flag; // RULE10
    if (first_buffer_flag) begin
      status_word[`RXDQ_ST_LEN_MSB:0] = pkt_len; // RULE12
    end
  end
endmodule // rxdq_status_fmt

// file: rxdq_sva.sv
/*
 * Checker of the receive descriptor DMA: status write-back, memory and FIFO handshakes, APB answers.
 * Assumes it is bound to rxdq_dma and sees only its ports.
 */
`timescale 1ns/1ps
module rxdq_sva #(
  parameter NCH = 2,
  parameter CHW = 1
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [3:0] mem_be,
  input wire [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  input wire fifo_valid,
  input wire [CHW-1:0] fifo_chan,
  input wire [7:0] fifo_data,
  input wire fifo_last,
  input wire fifo_zero,
  input wire fifo_ready,
  input wire busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------------------
  // Byte writes never use all four lanes, so a full-word write to word 3 is a status write.
  sequence s_status_wr;
    mem_req && mem_we && mem_be == 4'hF && mem_addr[3:0] == 4'hC;
  endsequence
  sequence s_take;
    fifo_valid && fifo_ready;
  endsequence
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_qend_needs_last: assert property (s_status_wr ##0 mem_wdata[28] |-> mem_wdata[30])
    else $error("Queue end written without last flag.");
  a_reserved_zero: assert property (s_status_wr |-> mem_wdata[27:24] == 4'h0 && mem_wdata[22:16] == 7'h00)
    else $error("Reserved status bits not zero.");
  a_owner_cleared: assert property (s_status_wr |-> !mem_wdata[29])
    else $error("Ownership left set in status write.");
  a_len_first_only: assert property (s_status_wr ##0 !mem_wdata[31] |-> mem_wdata[15:0] == 16'h0000)
    else $error("Packet length outside first descriptor.");
  a_zero_single: assert property (s_status_wr ##0 mem_wdata[23] |-> mem_wdata[31] && mem_wdata[30])
    else $error("Zero flag on a multi-buffer descriptor.");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("Memory request changed before ack.");
  // Byte writes carry the word address; the lane comes from the enable alone.
  a_byte_lane: assert property (mem_req && mem_we && mem_be != 4'hF |-> mem_addr[1:0] == 2'b00 && $onehot(mem_be) &&
                                mem_wdata == {4{mem_wdata[7:0]}})
    else $error("Byte write with wrong lane enable.");
  // While draining a cut packet, ready stays up between takes, so only the closing take must drop it.
  a_take_drop: assert property (s_take ##0 fifo_last |=> !fifo_ready)
    else $error("FIFO ready held after a take.");
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("No ready in first access cycle.");
  a_unmapped_err: assert property (psel && !penable && !pwrite && paddr == 12'hFFC |=> pslverr && prdata == 32'h0)
    else $error("Unmapped read not refused.");
endmodule // rxdq_sva

bind rxdq_dma rxdq_sva #(.NCH(NCH), .CHW(CHW)) u_rxdq_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack), .fifo_valid(fifo_valid), .fifo_chan(fifo_chan), .fifo_data(fifo_data),
  .fifo_last(fifo_last), .fifo_zero(fifo_zero), .fifo_ready(fifo_ready), .busy(busy));

// file: rxdq_mem_model.sv
/*
 * Word memory standing in for processor memory behind the DMA.
 * Assumes a request held until a one-cycle ack; 4 KB are modelled.
 */
`timescale 1ns/1ps
module rxdq_mem_model (
  input wire pclk,
  input wire presetn,
  input wire slow,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [3:0] mem_be,
  input wire [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] mem [0:1023];
  logic [1:0] wait_r;
  integer b;
  // Read data is only valid with ack; outside wait cycles it toggles so a stale sample shows up.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_r <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end else if (mem_req) begin
      mem_ack <= 1'b1;
      wait_r <= slow ? 2'h3 : 2'h0;
      if (mem_we) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (mem_be[b]) mem[mem_addr[11:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
        end
      end else mem_rdata <= mem[mem_addr[11:2]];
    end else mem_rdata <= ~mem_rdata;
  end
endmodule // rxdq_mem_model

// file: rx_descriptor_queue_dma_bench.sv
/*
 * Self-checking bench of the receive descriptor DMA with an APB master and FIFO driver.
 * Assumes rxdq_dma, rxdq_mem_model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
module rx_descriptor_queue_dma_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fifo_valid = 1'b0;
  logic [0:0] fifo_chan = 1'b0;
  logic [7:0] fifo_data = 8'h00;
  logic fifo_last = 1'b0;
  logic fifo_zero = 1'b0;
  logic slow = 1'b0;
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata;
  wire [3:0] mem_be;
  wire pready, pslverr, mem_req, mem_we, mem_ack, fifo_ready, busy;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] rng = 32'h0000_5210;
  logic [7:0] pk [0:15];
  logic [31:0] q;
  logic e;

  always #50 pclk = ~pclk;

  rxdq_dma #(.NCH(2), .CHW(1)) u_rxdq_dma (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .fifo_valid(fifo_valid), .fifo_chan(fifo_chan),
    .fifo_data(fifo_data), .fifo_last(fifo_last), .fifo_zero(fifo_zero), .fifo_ready(fifo_ready), .busy(busy));
  rxdq_mem_model u_rxdq_mem_model (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] rnd8();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  function automatic logic [31:0] mw(input logic [31:0] a);
    return u_rxdq_mem_model.mem[a[11:2]];
  endfunction
  function automatic logic [31:0] exp_st(input logic f, l, qe, z, input logic [15:0] n);
    return {f, l, 1'b0, qe, 4'h0, z, 7'h00, n};
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Holds the request until pready is seen high, then idles one cycle.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), ex, q);
  endtask
  // Software hands over clean descriptors with ownership given to the engine.
  task automatic mkdesc(input logic [31:0] a, nx, bf, ln);
    u_rxdq_mem_model.mem[a[11:2]] = nx;
    u_rxdq_mem_model.mem[a[11:2] + 1] = bf;
    u_rxdq_mem_model.mem[a[11:2] + 2] = ln;
    u_rxdq_mem_model.mem[a[11:2] + 3] = 32'h2000_0000;
  endtask
  // Waits have no limit of their own; a hang is caught by the watchdog.
  task automatic send(input logic ch, input int n, input logic z);
    int i;
    for (i = 0; i < n; i++) begin
      pk[i] = rnd8();
      fifo_valid <= 1'b1;
      fifo_chan <= ch;
      fifo_data <= pk[i];
      fifo_last <= (i == n - 1);
      fifo_zero <= z;
      do begin
        @(posedge pclk);
      end while (fifo_ready !== 1'b1);
    end
    fifo_valid <= 1'b0;
    fifo_last <= 1'b0;
    fifo_zero <= 1'b0;
    repeat (3) @(posedge pclk);
    while (busy !== 1'b0) begin
      @(posedge pclk);
    end
  endtask
  task automatic chkdata(input logic [31:0] bf, input int first, input int n);
    int i;
    logic [31:0] a;
    logic [31:0] w;
    for (i = 0; i < n; i++) begin
      a = bf + i;
      w = mw(a);
      chk("data", {24'h0, pk[first + i]}, {24'h0, w[8*a[1:0] +: 8]});
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h100, 32'h0);
    rd(12'h040, 32'h0);
    apb(1'b1, 12'hFFC, 32'h1234_5678);
    chk("slverr", 32'h1, {31'h0, e});
    rd(12'hFFC, 32'h0);
    $display("test registers done");
    mkdesc(32'h100, 32'h0, 32'h400, 32'd16);
    apb(1'b1, 12'h000, 32'h100);
    apb(1'b1, 12'h100, 32'h1);
    send(1'b0, 5, 1'b0);
    chk("single status", exp_st(1, 1, 1, 0, 16'd5), mw(32'h10C));
    chk("single len", 32'd5, mw(32'h108) & 32'h0000_FFFF);
    chkdata(32'h400, 0, 5);
    rd(12'h004, 32'h100);
    rd(12'h000, 32'h0);
    $display("test single buffer done");
    slow <= 1'b1;
    mkdesc(32'h200, 32'h210, 32'h500, 32'd4);
    mkdesc(32'h210, 32'h220, 32'h510, 32'd4);
    mkdesc(32'h220, 32'h230, 32'h520, 32'd4);
    mkdesc(32'h230, 32'h0, 32'h530, 32'd8);
    apb(1'b1, 12'h040, 32'h200);
    send(1'b1, 10, 1'b0);
    chk("first status", exp_st(1, 0, 0, 0, 16'd10), mw(32'h20C));
    chk("middle status", 32'h0, mw(32'h21C));
    chk("last status", exp_st(0, 1, 0, 0, 16'd0), mw(32'h22C));
    chk("last len", 32'd2, mw(32'h228) & 32'hFFFF);
    chkdata(32'h500, 0, 4);
    chkdata(32'h510, 4, 4);
    chkdata(32'h520, 8, 2);
    rd(12'h040, 32'h230);
    rd(12'h044, 32'h220);
    rd(12'h000, 32'h0);
    $display("test three buffers done");
    send(1'b1, 1, 1'b1);
    chk("zero status", exp_st(1, 1, 1, 1, 16'd0) >> 16, mw(32'h23C) >> 16);
    $display("test zero byte done");
    slow <= 1'b0;
    mkdesc(32'h300, 32'h0, 32'h600, 32'd4);
    u_rxdq_mem_model.mem[12'h604 >> 2] = 32'hA5A5_A5A5;
    apb(1'b1, 12'h000, 32'h300);
    send(1'b0, 6, 1'b0);
    chkdata(32'h600, 0, 4);
    chk("beyond buffer", 32'hA5A5_A5A5, mw(32'h604));
    chk("trunc flags", 32'hD, mw(32'h30C) >> 28);
    $display("test truncation done");
    conclude();
  end
endmodule // rx_descriptor_queue_dma_bench
